// >>> src/qfpce_pkg.sv
// qfpce_pkg: offsets, field positions, codes and reset values of the
// queue flush / printer port command executor.
// assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
package qfpce_pkg;
   // register byte addresses
   localparam logic [5:0] ADDR_CMD_CODE   = 6'h00;
   localparam logic [5:0] ADDR_OPTIONS    = 6'h04;
   localparam logic [5:0] ADDR_RET_STATUS = 6'h08;
   localparam logic [5:0] ADDR_VECTORS    = 6'h0C;
   localparam logic [5:0] ADDR_LEVEL      = 6'h10;
   localparam logic [5:0] ADDR_QUEUE_NUM  = 6'h14;
   localparam logic [5:0] ADDR_PRN_OPTS   = 6'h18;
   localparam logic [5:0] ADDR_COUNT      = 6'h1C;
   localparam logic [5:0] ADDR_INIT_W2    = 6'h20;
   localparam logic [5:0] ADDR_DOORBELL   = 6'h24;
   localparam logic [5:0] ADDR_PRN_TYPE   = 6'h28;
   // command codes
   localparam logic [15:0] CMD_FLUSH_WQ  = 16'h0049;
   localparam logic [15:0] CMD_PRN_INIT  = 16'h004A;
   // command options field positions
   localparam int OPT_INT_EN     = 0;
   localparam int OPT_REPORT     = 8;
   // vector word fields
   localparam int VEC_NORM_LSB   = 8;
   localparam int VEC_ERR_LSB    = 0;
   // count word fields
   localparam int CNT_WIDTH      = 14;
   localparam int CNT_PRIMARY    = 14;
   localparam int CNT_SECONDARY  = 15;
   // printer options field positions
   localparam int PO_STAT_EN_MSB = 7;
   localparam int PO_RSVD_LSB    = 4;
   localparam int PO_BUF_CLEAR   = 13;
   localparam int PO_ODD_PARITY  = 14;
   localparam int PO_PORT_RESET  = 15;
   // printer status line masks per printer type
   localparam logic [7:0] PRN_MASK_TYPE_A = 8'h0F;
   localparam logic [7:0] PRN_MASK_TYPE_B = 8'h07;
   // return status codes
   localparam logic [15:0] STS_OK            = 16'h0000;
   localparam logic [15:0] STS_ILLEGAL_PARAM = 16'h0019;
   localparam logic [15:0] STS_FLUSHED       = 16'h0001;
   localparam logic [15:0] STS_BAD_COMMAND   = 16'h0002;
   // reset values
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [13:0] RST_COUNT  = 14'h0000;
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [31:0] RD_ZERO    = 32'h00000000;
   // command engine states
   typedef enum logic [3:0] {
      QFPCE_IDLE,
      QFPCE_DECODE,
      QFPCE_FL_SCAN,
      QFPCE_FL_POP,
      QFPCE_FL_REPORT,
      QFPCE_PRN_RESET,
      QFPCE_FINISH,
      QFPCE_CMPL
   } qfpce_state_e;
endpackage

// >>> src/qfpce_stat_detect.sv
// qfpce_stat_detect: watches the printer status lines and raises a one-cycle
// status-change pulse for any changed line that is enabled and inside the printer type's mask.
// assumes status lines are synchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module qfpce_stat_detect
   import qfpce_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rstn_in,
   // configuration
   input  wire logic [7:0] enable_in,
   input  wire logic       type_b_in,
   input  wire logic       port_reset_in,
   // printer status
   input  wire logic [7:0] status_in,
   // change report
   output logic            change_out,
   output logic [7:0]      changed_bits_out
);
   logic [7:0] last_reg;
   logic       primed_reg;
   wire  [7:0] type_mask = type_b_in ? PRN_MASK_TYPE_B : PRN_MASK_TYPE_A;
   // lines are taken as active high, with no inversion
   wire  [7:0] diff      = (status_in ^ last_reg) & enable_in & type_mask;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in || port_reset_in) begin
         last_reg         <= RST_BYTE;
         primed_reg       <= 1'b0;
         change_out       <= 1'b0;
         changed_bits_out <= RST_BYTE;
      end else begin
         last_reg         <= status_in;
         primed_reg       <= 1'b1;
         change_out       <= primed_reg && (diff != RST_BYTE);
         changed_bits_out <= diff;
      end
   end
endmodule // qfpce_stat_detect
`default_nettype wire

// >>> src/qfpce_engine.sv
// qfpce_engine: executes the work queue flush and printer port initialise
// commands from a parameter block held in Avalon-MM registers.
// assumes a queue manager presents the entries of the selected queue one at
// a time, and a completion poster turns completions into bus interrupts.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module qfpce_engine
   import qfpce_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rstn_in,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   // work queue manager
   output logic [15:0]      fq_queue_out,
   output logic             fq_scan_out,
   output logic             fq_pop_out,
   input  wire logic        fq_avail_in,
   input  wire logic        fq_int_en_in,
   input  wire logic [7:0]  fq_err_vector_in,
   input  wire logic [2:0]  fq_level_in,
   input  wire logic        fq_in_progress_in,
   input  wire logic        fq_secondary_in,
   // completion poster
   output logic             cmpl_valid_out,
   output logic             cmpl_irq_out,
   output logic [2:0]       cmpl_level_out,
   output logic [7:0]       cmpl_vector_out,
   output logic [15:0]      cmpl_status_out,
   output logic             cmpl_entry_out,
   input  wire logic        cmpl_ready_in,
   // printer port
   input  wire logic [7:0]  prn_status_in,
   output logic             prn_buf_clear_out,
   output logic             prn_odd_parity_out,
   output logic             prn_port_reset_out,
   output logic             prn_accept_out,
   output logic             prn_stat_irq_out,
   output logic [7:0]       prn_stat_bits_out,
   output logic [7:0]       prn_stat_vector_out
);
   qfpce_state_e state_reg;
   qfpce_state_e state_next;

   logic [15:0] cmd_code_reg;
   logic [15:0] options_reg;
   logic [15:0] vectors_reg;
   logic [15:0] level_reg;
   logic [15:0] queue_reg;
   logic [15:0] prn_opts_reg;
   logic [15:0] init_w2_reg;
   logic        prn_type_b_reg;
   logic [15:0] ret_status_reg;
   logic [CNT_WIDTH-1:0] count_reg;
   logic        primary_bus_in_progress_reg;
   logic        secondary_bus_in_progress_reg;
   logic        busy_reg;
   logic        rd_valid_reg;
   logic [7:0]  stat_en_reg;
   logic        stat_change;
   logic [7:0]  stat_bits;

   // bus decode
   wire sel_cmd      = avs_address_in == ADDR_CMD_CODE;
   wire sel_opts     = avs_address_in == ADDR_OPTIONS;
   wire sel_status   = avs_address_in == ADDR_RET_STATUS;
   wire sel_vec      = avs_address_in == ADDR_VECTORS;
   wire sel_lvl      = avs_address_in == ADDR_LEVEL;
   wire sel_queue    = avs_address_in == ADDR_QUEUE_NUM;
   wire sel_popts    = avs_address_in == ADDR_PRN_OPTS;
   wire sel_count    = avs_address_in == ADDR_COUNT;
   wire sel_init     = avs_address_in == ADDR_INIT_W2;
   wire sel_door     = avs_address_in == ADDR_DOORBELL;
   wire sel_ptype    = avs_address_in == ADDR_PRN_TYPE;
   wire lo_lanes     = avs_byteenable_in[1:0] == 2'b11;
   // parameter block words are frozen while a command runs
   wire pb_wr        = avs_write_in && !busy_reg && lo_lanes;
   wire door_stall   = avs_write_in && sel_door && busy_reg;
   wire start        = avs_write_in && sel_door && !busy_reg && avs_byteenable_in[0]
                       && avs_writedata_in[0];

   wire [15:0] count_word = {secondary_bus_in_progress_reg,
                             primary_bus_in_progress_reg, count_reg};

   wire [31:0] rd_mux =
      sel_cmd    ? {16'h0000, cmd_code_reg}   :
      sel_opts   ? {16'h0000, options_reg}    :
      sel_status ? {16'h0000, ret_status_reg} :
      sel_vec    ? {16'h0000, vectors_reg}    :
      sel_lvl    ? {16'h0000, level_reg}      :
      sel_queue  ? {16'h0000, queue_reg}      :
      sel_popts  ? {16'h0000, prn_opts_reg}   :
      sel_count  ? {16'h0000, count_word}     :
      sel_init   ? {16'h0000, init_w2_reg}    :
      sel_door   ? {31'h00000000, busy_reg}   :
      sel_ptype  ? {31'h00000000, prn_type_b_reg} :
      RD_ZERO;

   // reads take one wait cycle so read data comes from a flip-flop
   assign avs_waitrequest_out = (avs_read_in && !rd_valid_reg) || door_stall;

   // command fields
   wire is_flush     = cmd_code_reg == CMD_FLUSH_WQ;
   wire is_prn       = cmd_code_reg == CMD_PRN_INIT;
   wire int_en       = options_reg[OPT_INT_EN];
   wire report_on    = options_reg[OPT_REPORT];
   wire [2:0] lvl    = level_reg[2:0];
   wire lvl_bad      = (int_en && lvl == 3'h0) || (level_reg[15:3] != 13'h0000);
   wire prn_rsvd_bad = (prn_opts_reg[PO_STAT_EN_MSB:PO_RSVD_LSB] != 4'h0)
                       || (prn_opts_reg[12:8] != 5'h00);
   wire [7:0] vec_norm = vectors_reg[VEC_NORM_LSB +: 8];
   wire [7:0] vec_err  = vectors_reg[VEC_ERR_LSB +: 8];
   wire cnt_full     = &count_reg;
   wire cmpl_taken   = cmpl_valid_out && cmpl_ready_in;

   // state transitions
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         QFPCE_IDLE: begin
            if (start) begin
               state_next = QFPCE_DECODE;
            end
         end
         QFPCE_DECODE: begin
            if (lvl_bad || !(is_flush || is_prn)) begin
               state_next = QFPCE_FINISH;
            end else if (is_flush) begin
               state_next = QFPCE_FL_SCAN;
            end else if (prn_rsvd_bad) begin
               state_next = QFPCE_FINISH;
            end else begin
               state_next = QFPCE_PRN_RESET;
            end
         end
         QFPCE_FL_SCAN: begin
            if (fq_avail_in) begin
               state_next = QFPCE_FL_POP;
            end else begin
               state_next = QFPCE_FINISH;
            end
         end
         QFPCE_FL_POP: begin
            state_next = report_on ? QFPCE_FL_REPORT : QFPCE_FL_SCAN;
         end
         QFPCE_FL_REPORT: begin
            if (cmpl_taken) begin
               state_next = QFPCE_FL_SCAN;
            end
         end
         QFPCE_PRN_RESET: begin
            state_next = QFPCE_FINISH;
         end
         QFPCE_FINISH: begin
            state_next = QFPCE_CMPL;
         end
         QFPCE_CMPL: begin
            if (cmpl_taken) begin
               state_next = QFPCE_IDLE;
            end
         end
         default: begin
            state_next = QFPCE_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         state_reg <= QFPCE_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // parameter block words written by software
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cmd_code_reg   <= RST_WORD;
         options_reg    <= RST_WORD;
         vectors_reg    <= RST_WORD;
         level_reg      <= RST_WORD;
         queue_reg      <= RST_WORD;
         prn_opts_reg   <= RST_WORD;
         init_w2_reg    <= RST_WORD;
         prn_type_b_reg <= 1'b0;
      end else if (pb_wr) begin
         if (sel_cmd)   cmd_code_reg   <= avs_writedata_in[15:0];
         if (sel_opts)  options_reg    <= avs_writedata_in[15:0];
         if (sel_vec)   vectors_reg    <= avs_writedata_in[15:0];
         if (sel_lvl)   level_reg      <= avs_writedata_in[15:0];
         if (sel_queue) queue_reg      <= avs_writedata_in[15:0];
         if (sel_popts) prn_opts_reg   <= avs_writedata_in[15:0];
         if (sel_init)  init_w2_reg    <= avs_writedata_in[15:0];
         if (sel_ptype) prn_type_b_reg <= avs_writedata_in[0];
      end
   end

   // read data and busy flag
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         rd_valid_reg     <= 1'b0;
         avs_readdata_out <= RD_ZERO;
         busy_reg         <= 1'b0;
      end else begin
         rd_valid_reg     <= avs_read_in && !rd_valid_reg;
         avs_readdata_out <= rd_mux;
         if (start) begin
            busy_reg <= 1'b1;
         end else if (state_reg == QFPCE_CMPL && cmpl_taken) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // flush counting and returned words
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         count_reg                     <= RST_COUNT;
         primary_bus_in_progress_reg   <= 1'b0;
         secondary_bus_in_progress_reg <= 1'b0;
         ret_status_reg                <= STS_OK;
      end else if (state_reg == QFPCE_DECODE) begin
         count_reg                     <= RST_COUNT;
         primary_bus_in_progress_reg   <= 1'b0;
         secondary_bus_in_progress_reg <= 1'b0;
      end else if (state_reg == QFPCE_FL_POP) begin
         if (!cnt_full) begin
            count_reg <= count_reg + 14'h0001;
         end
         // the queue holds at most its one in-progress entry; several
         // queues may share a bus, so the flags only ever set here
         if (fq_in_progress_in && !fq_secondary_in) begin
            primary_bus_in_progress_reg <= 1'b1;
         end
         if (fq_in_progress_in && fq_secondary_in) begin
            secondary_bus_in_progress_reg <= 1'b1;
         end
      end else if (state_reg == QFPCE_FINISH) begin
         if (lvl_bad || !(is_flush || is_prn)) begin
            ret_status_reg <= lvl_bad ? STS_ILLEGAL_PARAM : STS_BAD_COMMAND;
         end else if (is_prn && prn_rsvd_bad) begin
            ret_status_reg <= STS_ILLEGAL_PARAM;
         end else begin
            ret_status_reg <= STS_OK;
         end
      end
   end

   // queue manager side
   assign fq_queue_out = queue_reg;
   assign fq_scan_out  = state_reg == QFPCE_FL_SCAN;
   assign fq_pop_out   = state_reg == QFPCE_FL_POP;

   // completion output
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cmpl_valid_out  <= 1'b0;
         cmpl_irq_out    <= 1'b0;
         cmpl_level_out  <= 3'h0;
         cmpl_vector_out <= RST_BYTE;
         cmpl_status_out <= STS_OK;
         cmpl_entry_out  <= 1'b0;
      end else if (cmpl_taken) begin
         cmpl_valid_out <= 1'b0;
         cmpl_irq_out   <= 1'b0;
      end else if (state_reg == QFPCE_FL_POP && report_on) begin
         cmpl_valid_out  <= 1'b1;
         cmpl_irq_out    <= fq_int_en_in;
         cmpl_level_out  <= fq_level_in;
         cmpl_vector_out <= fq_err_vector_in;
         cmpl_status_out <= STS_FLUSHED;
         cmpl_entry_out  <= 1'b1;
      end else if (state_reg == QFPCE_FINISH) begin
         cmpl_valid_out  <= 1'b1;
         cmpl_irq_out    <= int_en && !lvl_bad;
         cmpl_level_out  <= lvl;
         cmpl_entry_out  <= 1'b0;
         if (lvl_bad || !(is_flush || is_prn) || (is_prn && prn_rsvd_bad)) begin
            cmpl_vector_out <= vec_err;
            cmpl_status_out <= lvl_bad ? STS_ILLEGAL_PARAM :
                               (is_prn ? STS_ILLEGAL_PARAM : STS_BAD_COMMAND);
         end else begin
            cmpl_vector_out <= vec_norm;
            cmpl_status_out <= STS_OK;
         end
      end
   end

   // printer port configuration
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         prn_buf_clear_out  <= 1'b0;
         prn_odd_parity_out <= 1'b0;
         prn_port_reset_out <= 1'b0;
         prn_accept_out     <= 1'b1;
         stat_en_reg        <= RST_BYTE;
      end else begin
         prn_port_reset_out <= 1'b0;
         if (state_reg == QFPCE_PRN_RESET) begin
            // the clear line holds until a later printer initialise command drops the bit
            prn_buf_clear_out  <= prn_opts_reg[PO_BUF_CLEAR];
            prn_odd_parity_out <= !prn_type_b_reg && prn_opts_reg[PO_ODD_PARITY];
            stat_en_reg        <= prn_opts_reg[PO_STAT_EN_MSB:0];
            if (prn_opts_reg[PO_PORT_RESET]) begin
               prn_port_reset_out <= 1'b1;
               prn_accept_out     <= 1'b0;
            end
         end else if (state_reg == QFPCE_CMPL && cmpl_taken) begin
            prn_accept_out <= 1'b1;
         end
      end
   end

   qfpce_stat_detect u_stat_detect (
      .sys_clk_in       (sys_clk_in),
      .rstn_in          (rstn_in),
      .enable_in        (stat_en_reg),
      .type_b_in        (prn_type_b_reg),
      .port_reset_in    (prn_port_reset_out),
      .status_in        (prn_status_in),
      .change_out       (stat_change),
      .changed_bits_out (stat_bits)
   );

   // status-change report carries its vector from init block word 2
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         prn_stat_irq_out    <= 1'b0;
         prn_stat_bits_out   <= RST_BYTE;
         prn_stat_vector_out <= RST_BYTE;
      end else begin
         prn_stat_irq_out    <= stat_change;
         prn_stat_bits_out   <= stat_bits;
         prn_stat_vector_out <= init_w2_reg[7:0];
      end
   end
endmodule // qfpce_engine
`default_nettype wire

// >>> verification/qfpce_engine_chk.sv
// qfpce_engine_chk: port-level assertions for the command engine.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module qfpce_engine_chk
   import qfpce_pkg::*;
(
   // clock, reset and bus
   input wire logic        sys_clk_in,
   input wire logic        rstn_in,
   input wire logic [5:0]  avs_address_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic        avs_waitrequest_out,
   // queue side
   input wire logic        fq_pop_out,
   input wire logic        fq_int_en_in,
   input wire logic [7:0]  fq_err_vector_in,
   // completion and printer
   input wire logic        cmpl_valid_out,
   input wire logic        cmpl_irq_out,
   input wire logic [2:0]  cmpl_level_out,
   input wire logic [7:0]  cmpl_vector_out,
   input wire logic [15:0] cmpl_status_out,
   input wire logic        cmpl_entry_out,
   input wire logic        cmpl_ready_in,
   input wire logic        prn_buf_clear_out,
   input wire logic        prn_stat_irq_out,
   input wire logic [7:0]  prn_stat_vector_out
);
   logic [15:0] opt_q, vec_q, lvl_q, w2_q;
   logic        busy_q;
   wire  [5:0]  ad   = avs_address_in;
   wire  [15:0] d    = avs_writedata_in[15:0];
   wire         take = avs_write_in && !avs_waitrequest_out && !busy_q;
   wire         ring = take && ad == ADDR_DOORBELL && d[0];
   wire         own  = cmpl_valid_out && !cmpl_entry_out;
   // parameter words as taken while idle
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) busy_q <= 1'b0;
      else if (ring) busy_q <= 1'b1;
      else if (own && cmpl_ready_in) busy_q <= 1'b0;
      if (take && ad == ADDR_OPTIONS) opt_q <= d;
      if (take && ad == ADDR_VECTORS) vec_q <= d;
      if (take && ad == ADDR_LEVEL) lvl_q <= d;
      if (take && ad == ADDR_INIT_W2) w2_q <= d;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   property p_hold; cmpl_valid_out && !cmpl_ready_in |=> cmpl_valid_out && $stable(cmpl_status_out); endproperty
   a_hold: assert property (p_hold) else $error("completion dropped early");
   property p_done; ring |-> ##[2:40] cmpl_valid_out; endproperty
   a_done: assert property (p_done) else $error("no completion");
   property p_vec; own |-> cmpl_vector_out == (cmpl_status_out == STS_OK ? vec_q[15:8] : vec_q[7:0]); endproperty
   a_vec: assert property (p_vec) else $error("wrong completion vector");
   property p_own; own && cmpl_status_out == STS_OK |-> cmpl_irq_out == opt_q[0]; endproperty
   a_own: assert property (p_own) else $error("wrong own irq");
   property p_lvl; own && cmpl_irq_out |-> cmpl_level_out == lvl_q[2:0] && lvl_q[15:3] == 13'h0000 && lvl_q[2:0] != 3'h0; endproperty
   a_lvl: assert property (p_lvl) else $error("wrong level");
   property p_rep; fq_pop_out && opt_q[8] |=> cmpl_valid_out && cmpl_entry_out && cmpl_irq_out == $past(fq_int_en_in) && cmpl_vector_out == $past(fq_err_vector_in); endproperty
   a_rep: assert property (p_rep) else $error("wrong entry report");
   property p_rstat; cmpl_valid_out && cmpl_entry_out |-> opt_q[8] && cmpl_status_out == STS_FLUSHED; endproperty
   a_rstat: assert property (p_rstat) else $error("unexpected entry report");
   property p_clr; !busy_q |=> $stable(prn_buf_clear_out); endproperty
   a_clr: assert property (p_clr) else $error("buffer clear moved while idle");
   property p_svec; prn_stat_irq_out |-> prn_stat_vector_out == w2_q[7:0]; endproperty
   a_svec: assert property (p_svec) else $error("wrong status vector");
   c_rep: cover property (fq_pop_out && opt_q[8]);
   c_bad: cover property (own && cmpl_status_out == STS_ILLEGAL_PARAM);
   c_stat: cover property (prn_stat_irq_out);
endmodule // qfpce_engine_chk
bind qfpce_engine qfpce_engine_chk u_chk (
   .sys_clk_in, .rstn_in, .avs_address_in, .avs_write_in, .avs_writedata_in,
   .avs_waitrequest_out, .fq_pop_out, .fq_int_en_in, .fq_err_vector_in, .cmpl_valid_out,
   .cmpl_irq_out, .cmpl_level_out, .cmpl_vector_out, .cmpl_status_out, .cmpl_entry_out,
   .cmpl_ready_in, .prn_buf_clear_out, .prn_stat_irq_out, .prn_stat_vector_out);
`default_nettype wire

// >>> verification/qfpce_queue_model.sv
// qfpce_queue_model: work queue manager holding the entries of one queue.
// assumes it is loaded only while the engine is idle.
`timescale 1ns/1ps
`default_nettype none
module qfpce_queue_model (
   // clock, reset and load
   input  wire logic       sys_clk_in,
   input  wire logic       rstn_in,
   input  wire logic       load_in,
   input  wire logic [3:0] n_in,
   input  wire logic       sec_in,
   // engine side
   input  wire logic       fq_pop_in,
   output logic            avail_out,
   output logic            int_en_out,
   output logic [7:0]      err_vec_out,
   output logic [2:0]      level_out,
   output logic            in_prog_out,
   output logic            sec_out
);
   logic [3:0] left_reg;
   logic       tog_reg;
   always_ff @(posedge sys_clk_in) begin
      tog_reg <= rstn_in ? ~tog_reg : 1'b0;
      if (!rstn_in) left_reg <= 4'h0;
      else if (load_in) left_reg <= n_in;
      else if (fq_pop_in && avail_out) left_reg <= left_reg - 4'h1;
   end
   // fields wander while empty
   assign avail_out   = left_reg != 4'h0;
   assign int_en_out  = avail_out ? left_reg[0] : tog_reg;
   assign err_vec_out = avail_out ? {4'hA, left_reg} : {8{tog_reg}};
   assign level_out   = avail_out ? left_reg[2:0] : {3{tog_reg}};
   assign in_prog_out = avail_out ? left_reg == 4'h1 : tog_reg;
   assign sec_out     = avail_out ? sec_in : tog_reg;
endmodule // qfpce_queue_model
`default_nettype wire

// >>> verification/qfpce_engine_tb.sv
// qfpce_engine_tb: random and corner command runs against the engine.
// assumes the queue model stands in for the queue manager.
`timescale 1ns/1ps
`default_nettype none
module qfpce_engine_tb
   import qfpce_pkg::*;
;
   logic        clk = 0, rstn = 0, rd = 0, wr = 0, rdy = 0, ld = 0, sc = 0;
   logic [5:0]  ad = 6'h00;
   logic [31:0] wd = 32'h00000000, rdat, rdata;
   logic [7:0]  pst = 8'h00, ev, cvec, sbits, svec;
   logic [3:0]  nq = 4'h0;
   logic [15:0] cs, fqn;
   logic [2:0]  lv;
   logic        wreq, pop, av, ie, ip, sb, cv, ci, ce, bclr, par, acc, sirq;
   int          n_fail = 0, samples_checked = 0, seed = 43412;
   always #5 clk = ~clk;
   qfpce_engine dut (
      .sys_clk_in(clk), .rstn_in(rstn), .avs_address_in(ad), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .fq_queue_out(fqn),
      .fq_scan_out(), .fq_pop_out(pop), .fq_avail_in(av), .fq_int_en_in(ie),
      .fq_err_vector_in(ev), .fq_level_in(lv), .fq_in_progress_in(ip),
      .fq_secondary_in(sb), .cmpl_valid_out(cv), .cmpl_irq_out(ci), .cmpl_level_out(),
      .cmpl_vector_out(cvec), .cmpl_status_out(cs), .cmpl_entry_out(ce),
      .cmpl_ready_in(rdy), .prn_status_in(pst), .prn_buf_clear_out(bclr),
      .prn_odd_parity_out(par), .prn_port_reset_out(), .prn_accept_out(acc),
      .prn_stat_irq_out(sirq), .prn_stat_bits_out(sbits), .prn_stat_vector_out(svec));
   qfpce_queue_model u_q (.sys_clk_in(clk), .rstn_in(rstn), .load_in(ld), .n_in(nq),
      .sec_in(sc), .fq_pop_in(pop), .avail_out(av), .int_en_out(ie), .err_vec_out(ev),
      .level_out(lv), .in_prog_out(ip), .sec_out(sb));
   task automatic results;
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(logic w, logic [5:0] a, logic [15:0] d);
      int i;
      @(posedge clk);
      {wr, rd, ad, wd} <= {w, ~w, a, 16'h0000, d};
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      if (i == 50) n_fail++;
      if (i == 50) results();
      rdat = rdata;
      {wr, rd} <= 2'b00;
   endtask
   task automatic cmd(logic [15:0] code, opt, lvl, popt, logic [3:0] n, logic s);
      logic [15:0] vec, st;
      logic [3:0]  k;
      logic        own;
      int          i, r = 0;
      vec = 16'($random(seed));
      st = (code != CMD_FLUSH_WQ && code != CMD_PRN_INIT) ? STS_BAD_COMMAND :
           (lvl[15:3] != 13'h0000 || (lvl[2:0] == 3'h0 && opt[0])) ? STS_ILLEGAL_PARAM : STS_OK;
      bus(1, ADDR_CMD_CODE, code);
      bus(1, ADDR_OPTIONS, opt);
      bus(1, ADDR_VECTORS, vec);
      bus(1, ADDR_LEVEL, lvl);
      bus(1, ADDR_PRN_OPTS, popt);
      @(posedge clk);
      {ld, nq, sc} <= {1'b1, n, s};
      @(posedge clk);
      ld <= 1'b0;
      bus(1, ADDR_DOORBELL, 16'h0001);
      do begin
         for (i = 0; i < 100; i++) begin
            @(negedge clk);
            if (cv === 1'b1) break;
         end
         if (i == 100) n_fail++;
         if (i == 100) results();
         own = ce !== 1'b1;
         if (!own) begin
            r++;
            k = n - 4'(r) + 4'h1;
            chk("entry_status", STS_FLUSHED, cs);
            chk("entry_irq", 16'(k[0]), 16'(ci));
            chk("entry_vec", {8'h00, 4'hA, k}, 16'(cvec));
         end else begin
            chk("status", st, cs);
            chk("queue", 16'h0005, fqn);
            chk("vector", 16'(st == STS_OK ? vec[15:8] : vec[7:0]), 16'(cvec));
            chk("irq", 16'(st == STS_OK && opt[0]), 16'(ci));
            if (popt[15] && st == STS_OK) chk("accept", 16'h0000, 16'(acc));
         end
         repeat (1 + $unsigned($random(seed)) % 3) @(posedge clk);
         rdy <= 1'b1;
         @(posedge clk);
         rdy <= 1'b0;
      end while (!own);
      if (code == CMD_FLUSH_WQ && st == STS_OK) begin
         chk("reports", opt[8] ? 16'(n) : 16'h0000, 16'(r));
         bus(0, ADDR_COUNT, 16'h0000);
         chk("count", {n != 0 && s, n != 0 && !s, 10'h000, n}, rdat[15:0]);
      end
      bus(0, ADDR_RET_STATUS, 16'h0000);
      chk("ret_status", st, rdat[15:0]);
   endtask
   initial begin
      logic [31:0] r;
      int          t;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      bus(1, ADDR_INIT_W2, 16'h12B7);
      bus(1, ADDR_QUEUE_NUM, 16'h0005);
      bus(0, 6'h3C, 16'h0000);
      chk("unmapped", 16'h0000, rdat[15:0]);
      for (t = 0; t < 16; t++) begin
         r = $random(seed);
         cmd(CMD_FLUSH_WQ, {7'h00, r[0], 7'h00, r[1]}, {13'h0000, r[4:2]}, 16'h0000, r[8:5], r[9]);
      end
      cmd(CMD_FLUSH_WQ, 16'h0101, 16'h0007, 16'h0000, 4'hF, 1'b1);
      cmd(CMD_FLUSH_WQ, 16'h0100, 16'h0008, 16'h0000, 4'h0, 1'b0);
      cmd(16'h0077, 16'h0000, 16'h0001, 16'h0000, 4'h0, 1'b0);
      bus(1, ADDR_PRN_TYPE, 16'h0000);
      cmd(CMD_PRN_INIT, 16'h0001, 16'h0002, 16'hE001, 4'h0, 1'b0);
      @(negedge clk);
      chk("buf_clear", 16'h0001, 16'(bclr));
      chk("parity", 16'h0001, 16'(par));
      chk("accept", 16'h0001, 16'(acc));
      @(posedge clk);
      pst <= 8'h10;
      for (t = 0; t < 6; t++) begin
         @(negedge clk);
         chk("stat_irq", 16'h0000, 16'(sirq));
      end
      @(posedge clk);
      pst <= 8'h11;
      for (t = 0; t < 6 && sirq !== 1'b1; t++) @(negedge clk);
      chk("stat_bits", 16'h0001, 16'(sbits));
      chk("stat_vec", 16'h00B7, 16'(svec));
      cmd(CMD_PRN_INIT, 16'h0000, 16'h0000, 16'h0000, 4'h0, 1'b0);
      @(negedge clk);
      chk("buf_clear", 16'h0000, 16'(bclr));
      bus(1, ADDR_PRN_TYPE, 16'h0001);
      cmd(CMD_PRN_INIT, 16'h0000, 16'h0000, 16'h4000, 4'h0, 1'b0);
      @(negedge clk);
      chk("parity", 16'h0000, 16'(par));
      results();
   end
endmodule // qfpce_engine_tb
`default_nettype wire
